// file: verilog/crstsq_top.sv
// chip reset sequencer: merges reset sources, stretches and records cause
`timescale 1ns/1ps
//
// Behaviour
// - internal reset is asserted for pin low, watchdog timer or core system-reset request.
// - the cause of the latest reset is kept in reset_source_flags for software.
// - after the pin goes high internal reset stays asserted for about 1.6 ms.
// - watchdog or system-request resets release about 30 oscillator cycles after start.
// - any reset returns all core and peripheral control registers to initial values.
// - after release the chip runs from the internal high-speed oscillator.
// - internal RAM contents are not guaranteed across any reset.
// - the core fault-halt indication causes no reset and no other action.
// - restoring power after a loss repeats the same cold sequence.
module crstsq_top #(
    parameter int unsigned STRETCH_CYC = crstsq_pkg::PIN_STRETCH_CYC
) (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic nrst,
    // reset sources
    input wire logic reset_pin_n,
    input wire logic watchdog_timer,
    input wire logic core_sys_reset_request,
    input wire logic core_fault_halt,
    // chip-side outputs
    output crstsq_pkg::crstsq_out_type chip_ctl,
    output logic chip_reset_n
);
    import crstsq_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        crstsq_state_type st;
        logic [CNT_W-1:0] cnt;
        logic [FLAG_W-1:0] flags;
        logic rst;
        logic [CNT_W-1:0] hold_seen;
    } crstsq_reg_type;

    crstsq_reg_type r_q;
    crstsq_reg_type r_d;
    logic pin_n_s;
    crstsq_src_type src;
    logic unused_halt;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    crstsq_pin_sync u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin_n(reset_pin_n),
        .pin_n_sync(pin_n_s)
    );

    // fault halt is deliberately ignored; only NMI or a reset recovers the core
    assign unused_halt = core_fault_halt;

    function automatic logic [CNT_W-1:0] cnt_of(input int unsigned v);
        return v[CNT_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        src.pin_low = !pin_n_s;
        src.watchdog_timer = watchdog_timer;
        src.core_sys_reset_request = core_sys_reset_request;
        case (r_q.st)
            ST_PIN_HOLD: begin
                r_d.rst = 1'b1;
                if (!src.pin_low) begin
                    r_d.st = ST_STRETCH;
                    r_d.cnt = cnt_of(STRETCH_CYC - 1);
                end
            end
            ST_STRETCH: begin
                r_d.rst = 1'b1;
                if (src.pin_low) begin
                    r_d.st = ST_PIN_HOLD;
                end else if (r_q.cnt == '0) begin
                    r_d.st = ST_RUN;
                    r_d.rst = 1'b0;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end
            end
            ST_INT_HOLD: begin
                r_d.rst = 1'b1;
                if (src.pin_low) begin
                    r_d.st = ST_PIN_HOLD;
                    r_d.flags = FLAG_PIN;
                end else if (r_q.cnt == '0) begin
                    r_d.st = ST_RUN;
                    r_d.rst = 1'b0;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end
            end
            ST_RUN: begin
                r_d.rst = 1'b0;
                // pin wins over internal sources when they coincide
                if (src.pin_low) begin
                    r_d.st = ST_PIN_HOLD;
                    r_d.rst = 1'b1;
                    r_d.flags = FLAG_PIN;
                end else if (src.watchdog_timer || src.core_sys_reset_request) begin
                    r_d.st = ST_INT_HOLD;
                    r_d.rst = 1'b1;
                    r_d.cnt = cnt_of(INT_HOLD_CYC - 1);
                    r_d.flags = src.watchdog_timer ? FLAG_WDOG : FLAG_SYSREQ;
                end
            end
            default: begin
                r_d.st = ST_PIN_HOLD;
                r_d.rst = 1'b1;
            end
        endcase
        // cycles spent in internal hold, counted apart from cnt so the checks stay independent
        if (r_d.st == ST_INT_HOLD) begin
            r_d.hold_seen = r_q.hold_seen + 1'b1;
        end else begin
            r_d.hold_seen = '0;
        end
    end

    // power-on starts in pin hold, giving the cold sequence each time
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_q.st <= ST_PIN_HOLD;
            r_q.cnt <= '0;
            r_q.flags <= FLAG_RESET;
            r_q.rst <= 1'b1;
            r_q.hold_seen <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // one registered release edge for the whole chip; RAM is not cleared here
    assign chip_reset_n = !r_q.rst;
    // clock select is tied: reset always hands over on the internal oscillator
    assign chip_ctl = '{chip_reset: r_q.rst, clk_sel_ihosc: 1'b1, reset_source_flags: r_q.flags};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_pin_asserts: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_RUN && !pin_n_s) |=> chip_reset_n == 1'b0)
        else $error("pin low did not assert reset");
    chk_int_asserts: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_RUN && pin_n_s && (watchdog_timer || core_sys_reset_request))
        |=> !chip_reset_n)
        else $error("internal request did not assert reset");
    chk_flag_wdog: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_RUN && pin_n_s && watchdog_timer)
        |=> chip_ctl.reset_source_flags == FLAG_WDOG)
        else $error("watchdog cause not recorded");
    chk_flag_pin: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_RUN && !pin_n_s) |=> chip_ctl.reset_source_flags == FLAG_PIN)
        else $error("pin cause not recorded");
    chk_int_hold_len: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_INT_HOLD && r_q.hold_seen < cnt_of(INT_HOLD_CYC)) |=> !chip_reset_n)
        else $error("internal reset released before 30 cycles");
    chk_int_hold_end: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_INT_HOLD && r_q.hold_seen == cnt_of(INT_HOLD_CYC) && pin_n_s)
        |=> chip_reset_n)
        else $error("internal reset not released after 30 cycles");
    chk_stretch_min: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_PIN_HOLD && pin_n_s) |=> !chip_reset_n [*8])
        else $error("reset released too early after pin");
    chk_stretch_end: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_STRETCH && r_q.cnt == '0 && pin_n_s) |=> chip_reset_n)
        else $error("stretch did not end with release");
    chk_halt_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
        (r_q.st == ST_RUN && pin_n_s && !watchdog_timer && !core_sys_reset_request)
        |=> chip_reset_n)
        else $error("reset without a source");
    chk_ihosc_sel: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(chip_reset_n) |-> chip_ctl.clk_sel_ihosc)
        else $error("not running from internal oscillator");

endmodule

// file: inc/crstsq_pkg.sv
// package of constants and carrier types for the chip reset sequencer
package crstsq_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned CLK_PERIOD_PS = 25_000;
    // stretch after the pin rises, in microseconds
    localparam int unsigned PIN_STRETCH_US = 1600;
    localparam int unsigned PIN_STRETCH_CYC = (PIN_STRETCH_US * 1000) / (CLK_PERIOD_PS / 1000);
    // internal sources hold reset this many oscillator cycles
    localparam int unsigned INT_HOLD_CYC = 30;
    localparam int unsigned CNT_W = 17;

    // ------------------------------------------------------------
    // reset-source flag layout
    // ------------------------------------------------------------
    localparam int unsigned FLAG_W = 3;
    localparam logic [FLAG_W-1:0] FLAG_PIN = 3'h1;
    localparam logic [FLAG_W-1:0] FLAG_WDOG = 3'h2;
    localparam logic [FLAG_W-1:0] FLAG_SYSREQ = 3'h4;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_PIN_HOLD,
        ST_STRETCH,
        ST_INT_HOLD,
        ST_RUN
    } crstsq_state_type;

    // reset request inputs, all active high
    typedef struct packed {
        logic pin_low;
        logic watchdog_timer;
        logic core_sys_reset_request;
    } crstsq_src_type;

    // outputs towards the chip
    typedef struct packed {
        logic chip_reset;
        logic clk_sel_ihosc;
        logic [FLAG_W-1:0] reset_source_flags;
    } crstsq_out_type;

endpackage

// file: verilog/crstsq_pin_sync.sv
// two-flop synchroniser for the external reset pin
`timescale 1ns/1ps
module crstsq_pin_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pin and synchronised level
    input wire logic pin_n,
    output logic pin_n_sync
);
    import crstsq_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
    } crstsq_sync_type;

    crstsq_sync_type sync_q;
    crstsq_sync_type sync_d;

    always_comb begin
        sync_d = sync_q;
        sync_d.meta = pin_n;
        sync_d.sync = sync_q.meta;
    end

    // resets to low so the pin reads as asserted until seen high twice
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign pin_n_sync = sync_q.sync;

endmodule

// file: sim/crstsq_supervisor.sv
// board reset supervisor model driving the external reset pin
`timescale 1ns/1ps
module crstsq_supervisor #(
    parameter int unsigned POR_HOLD = 40,
    parameter int unsigned WARM_LOW = 12
) (
    // clock
    input wire logic core_clk,
    // requests from the bench
    input wire logic cold_req,
    input wire logic warm_req,
    // pin and status
    output logic reset_pin_n,
    output logic busy
);
    // pin low from time zero: supply ramps with the pin held down
    int unsigned cnt_q = POR_HOLD;

    always @(posedge core_clk) begin
        if (cold_req) begin
            cnt_q <= POR_HOLD;
        end else if (warm_req) begin
            cnt_q <= WARM_LOW;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    // push-pull driver, so the pin is never left floating
    assign reset_pin_n = (cnt_q == 0);
    assign busy = (cnt_q != 0);
endmodule

// file: sim/crstsq_bench.sv
// self-checking bench for the chip reset sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module crstsq_bench;
    import crstsq_pkg::*;
    // small stretch keeps the run short; count_low gives up after 300 cycles, far below the full count
    localparam int unsigned STR = 20;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wd = 1'b0;
    logic sreq = 1'b0;
    logic halt = 1'b0;
    logic cold_req = 1'b0;
    logic warm_req = 1'b0;
    logic pin_n;
    logic busy;
    crstsq_out_type chip_ctl;
    logic chip_reset_n;
    int errors = 0;
    int check_count = 0;

    always #12.5 core_clk = ~core_clk;

    crstsq_supervisor crstsq_supervisor_inst (.core_clk(core_clk), .cold_req(cold_req),
        .warm_req(warm_req), .reset_pin_n(pin_n), .busy(busy));
    crstsq_top #(.STRETCH_CYC(STR)) crstsq_top_inst (.core_clk(core_clk), .nrst(nrst),
        .reset_pin_n(pin_n), .watchdog_timer(wd), .core_sys_reset_request(sreq),
        .core_fault_halt(halt), .chip_ctl(chip_ctl), .chip_reset_n(chip_reset_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test;
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // counts cycles with internal reset asserted, ends at the first release
    task automatic count_low(output int n);
        n = 0;
        #1;
        for (int k = 0; k < 300; k++) begin
            if (chip_reset_n === 1'b0) n++;
            else if (n > 0) return;
            @(posedge core_clk);
            #1;
        end
        errors++;
        stop_test();
    endtask

    task automatic wait_pin;
        // let the supervisor take the request before looking at busy
        #1;
        for (int k = 0; k < 100 && busy === 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        if (busy !== 1'b0) begin
            errors++;
            stop_test();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power;
        int n;
        @(posedge core_clk);
        nrst <= 1'b0;
        cold_req <= 1'b1;
        @(posedge core_clk);
        cold_req <= 1'b0;
        #1;
        `CHK("por_reset_n", 1'b0, chip_reset_n)
        `CHK("por_flags", FLAG_RESET, chip_ctl.reset_source_flags)
        repeat (9) @(posedge core_clk);
        nrst <= 1'b1;
        wait_pin();
        `CHK("por_hold", 1'b0, chip_reset_n)
        count_low(n);
        `CHK("por_stretch", 1'b1, (n >= STR && n <= STR + 6))
        `CHK("por_clk_sel", 1'b1, chip_ctl.clk_sel_ihosc)
        `CHK("por_chip_reset", 1'b0, chip_ctl.chip_reset)
        `CHK("por_cause", FLAG_PIN, chip_ctl.reset_source_flags)
    endtask

    task automatic t_internal(input logic w, input logic s, input logic [FLAG_W-1:0] exp);
        int n;
        @(posedge core_clk);
        wd <= w;
        sreq <= s; // requests are raised only at full clock speed
        @(posedge core_clk);
        wd <= 1'b0;
        sreq <= 1'b0;
        count_low(n);
        `CHK("int_hold_len", 30, n)
        `CHK("int_cause", exp, chip_ctl.reset_source_flags)
    endtask

    task automatic t_halt;
        int bad;
        bad = 0;
        @(posedge core_clk);
        halt <= 1'b1;
        repeat (40) begin
            @(posedge core_clk);
            #1;
            if (chip_reset_n !== 1'b1) bad++;
        end
        halt <= 1'b0;
        `CHK("halt_quiet", 0, bad)
        `CHK("halt_flags", FLAG_WDOG, chip_ctl.reset_source_flags)
    endtask

    task automatic t_warm;
        int n;
        @(posedge core_clk);
        warm_req <= 1'b1;
        @(posedge core_clk);
        warm_req <= 1'b0;
        wait_pin();
        `CHK("warm_reset_n", 1'b0, chip_reset_n)
        `CHK("warm_chip_reset", 1'b1, chip_ctl.chip_reset)
        `CHK("warm_cause", FLAG_PIN, chip_ctl.reset_source_flags)
        count_low(n);
        `CHK("warm_stretch", 1'b1, (n >= STR && n <= STR + 6))
    endtask

    initial begin
        t_power();
        t_internal(1'b1, 1'b0, FLAG_WDOG);
        t_internal(1'b0, 1'b1, FLAG_SYSREQ);
        t_internal(1'b1, 1'b1, FLAG_WDOG);
        t_halt();
        t_warm();
        t_power();
        stop_test();
    end
endmodule
